// ### include/start_sel_pkg.sv
package start_sel_pkg;

  // Stop behaviour decoded from the stop selection setting.
  typedef enum logic [2:0] {
    MODE_DECEL = 3'b001,
    MODE_COAST = 3'b010,
    MODE_RPD_DECEL = 3'b100
  } stop_mode_t;

  // Drive state of the motor command.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_DECEL = 4'b0100,
    ST_COAST = 4'b1000
  } drive_state_t;

endpackage

// ### include/start_sel_regs.svh
`ifndef START_SEL_REGS_SVH
`define START_SEL_REGS_SVH

// Register byte addresses on the APB slave.
`define SS_ADDR_STOP_SEL 12'h000
`define SS_ADDR_VISIBILITY 12'h004
`define SS_ADDR_TERM_FN 12'h008
`define SS_ADDR_STATUS 12'h00C

// Reset values.
`define SS_STOP_SEL_RESET 14'h270F
`define SS_VISIBILITY_RESET 1'h0
`define SS_FWD_FN_RESET 8'h3C
`define SS_REV_FN_RESET 8'h3D
`define SS_STOP_FN_RESET 8'h00

// Setting values and ranges.
`define SS_SEL_COAST_MAX 14'h0064
`define SS_SEL_RPD_MIN 14'h03E8
`define SS_SEL_RPD_MAX 14'h044C
`define SS_SEL_DECEL 14'h270F
`define SS_SEL_RPD_DECEL 14'h22B8
`define SS_FN_STOP_HOLD 8'h19
`define SS_FN_FWD_START 8'h3C
`define SS_FN_REV_START 8'h3D

// Term function register field positions.
`define SS_FN_FWD_LSB 0
`define SS_FN_REV_LSB 8
`define SS_FN_STOP_LSB 16

// One second and the 100 MHz clock period, both in nanoseconds.
`define SS_SECOND_NS 1000000000
`define SS_CLK_NS 10

`endif

// ### logic/coast_delay_timer.sv
`timescale 1ns/1ps
`include "start_sel_regs.svh"

// ****************************************************************
// Seconds timer for the delayed coast after a start is removed.
// ****************************************************************
module coast_delay_timer #(
  parameter int unsigned SEC_CYCLES = `SS_SECOND_NS / `SS_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm,
  input wire logic [6:0] seconds,
  output logic expired
);

  logic [31:0] tick_q;
  logic [6:0] sec_q;
  logic running_q;

  // Count cycles to whole seconds while armed; rearming restarts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 32'h0;
      sec_q <= 7'h0;
      running_q <= 1'b0;
    end else if (!arm) begin
      tick_q <= 32'h0;
      sec_q <= 7'h0;
      running_q <= 1'b0;
    end else begin
      running_q <= 1'b1;
      if (sec_q != seconds) begin
        if (tick_q == SEC_CYCLES - 1) begin
          tick_q <= 32'h0;
          sec_q <= sec_q + 7'h1;
        end else begin
          tick_q <= tick_q + 32'h1;
        end
      end
    end
  end

  // A zero setting expires one cycle after arming.
  assign expired = running_q && arm && (sec_q == seconds);

endmodule

// ### logic/start_hold_latch.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-holding start latch for three-wire operation.
// ****************************************************************
module start_hold_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold_en,
  input wire logic fwd_in,
  input wire logic rev_in,
  output logic held_run,
  output logic held_rev
);

  logic fwd_q;
  logic rev_q;
  logic run_q;
  logic dir_q;

  // A start is taken on the falling edge of its trigger; releasing
  // the stop-hold input clears the latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      run_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      fwd_q <= fwd_in;
      rev_q <= rev_in;
      if (!hold_en) begin
        run_q <= 1'b0;
      end else if (fwd_q && !fwd_in) begin
        run_q <= 1'b1;
        dir_q <= 1'b0;
      end else if (rev_q && !rev_in) begin
        run_q <= 1'b1;
        dir_q <= 1'b1;
      end
    end
  end

  assign held_run = run_q;
  assign held_rev = dir_q;

endmodule

// ### logic/start_signal_decoder.sv
`timescale 1ns/1ps
`include "start_sel_regs.svh"

module start_signal_decoder #(
  parameter int unsigned SEC_CYCLES = `SS_SECOND_NS / `SS_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fwd_start_input,
  input wire logic rev_start_input,
  input wire logic stop_terminal_input,
  input wire logic jog_input,
  input wire logic output_shutoff_input,
  output logic run_fwd,
  output logic run_rev,
  output logic decel_stop,
  output logic drive_enable
);

  // ****************************************************************
  // Register file
  // ****************************************************************

  logic [13:0] stop_sel_q;
  logic vis_q;
  logic [7:0] fwd_fn_q;
  logic [7:0] rev_fn_q;
  logic [7:0] stop_fn_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  // Latch status, shown in the status word and driven further down.
  logic hold_active;
  logic hold_run;

  start_sel_pkg::drive_state_t state_q;
  start_sel_pkg::drive_state_t state_d;

  // Writes and reads complete in the first access cycle. Zero wait
  // states keep the slave simple, since nothing here needs more time.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == `SS_ADDR_STOP_SEL) ||
                   (paddr == `SS_ADDR_VISIBILITY) ||
                   (paddr == `SS_ADDR_TERM_FN) ||
                   (paddr == `SS_ADDR_STATUS);
  // Unmapped places answer with an error and change nothing, so a
  // stray write cannot disturb the drive.
  assign pslverr = psel && penable && !addr_ok;

  // Only recognised settings are accepted, otherwise the old one stays.
  // A bad value is dropped rather than clipped, because the nearest
  // legal setting may well choose a different stop method.
  function automatic logic sel_legal(input logic [13:0] v);
    sel_legal = (v <= `SS_SEL_COAST_MAX) ||
                ((v >= `SS_SEL_RPD_MIN) && (v <= `SS_SEL_RPD_MAX)) ||
                (v == `SS_SEL_DECEL) || (v == `SS_SEL_RPD_DECEL);
  endfunction

  // Stop selection is locked unless extended visibility is zero.
  // A locked write is simply lost; there is no error response.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_sel_q <= `SS_STOP_SEL_RESET;
    end else if (wr_en && paddr == `SS_ADDR_STOP_SEL && !vis_q &&
                 pwdata[31:14] == 18'h0 && sel_legal(pwdata[13:0])) begin
      stop_sel_q <= pwdata[13:0];
    end
  end

  // Visibility setting itself is always writable.
  // It gates the other settings, so it must never lock itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vis_q <= `SS_VISIBILITY_RESET;
    end else if (wr_en && paddr == `SS_ADDR_VISIBILITY) begin
      vis_q <= pwdata[0];
    end
  end

  // Forward and reverse selectors refuse only the other's start code;
  // any other code, stop-hold or nothing included, is accepted.
  // A refused field keeps its old code while the others still update.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_fn_q <= `SS_FWD_FN_RESET;
      rev_fn_q <= `SS_REV_FN_RESET;
      stop_fn_q <= `SS_STOP_FN_RESET;
    end else if (wr_en && paddr == `SS_ADDR_TERM_FN && !vis_q) begin
      if (pwdata[`SS_FN_FWD_LSB +: 8] != `SS_FN_REV_START) begin
        fwd_fn_q <= pwdata[`SS_FN_FWD_LSB +: 8];
      end
      if (pwdata[`SS_FN_REV_LSB +: 8] != `SS_FN_FWD_START) begin
        rev_fn_q <= pwdata[`SS_FN_REV_LSB +: 8];
      end
      if (pwdata[`SS_FN_STOP_LSB +: 8] != `SS_FN_FWD_START &&
          pwdata[`SS_FN_STOP_LSB +: 8] != `SS_FN_REV_START) begin
        stop_fn_q <= pwdata[`SS_FN_STOP_LSB +: 8];
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  // A read has no side effect, so polling the status word is safe.
  always_comb begin
    rdata_d = 32'h0;
    unique case (paddr)
      `SS_ADDR_STOP_SEL: rdata_d = {18'h0, stop_sel_q};
      `SS_ADDR_VISIBILITY: rdata_d = {31'h0, vis_q};
      `SS_ADDR_TERM_FN: rdata_d = {8'h0, stop_fn_q, rev_fn_q, fwd_fn_q};
      `SS_ADDR_STATUS: rdata_d = {24'h0, hold_run, hold_active,
                                  drive_enable, decel_stop,
                                  run_rev, run_fwd, state_q[3:2]};
      default: rdata_d = 32'h0;
    endcase
  end

  // Read data is registered on the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (rd_en) begin
      prdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Terminal routing
  // ****************************************************************

  logic fwd_in;
  logic rev_in;
  logic stop_in;
  logic hold_rev;

  // Start signals reach the decoder only through their own terminal.
  // terminal routing
  assign fwd_in = fwd_start_input && (fwd_fn_q == `SS_FN_FWD_START);
  assign rev_in = rev_start_input && (rev_fn_q == `SS_FN_REV_START);

  // Stop-hold from the dedicated terminal or a reassigned start pin.
  // A start pin given the stop-hold code loses its start role, because
  // its own selector no longer holds the start code.
  // code 25 routing
  assign stop_in = (stop_terminal_input &&
                    stop_fn_q == `SS_FN_STOP_HOLD) ||
                   (fwd_start_input && fwd_fn_q == `SS_FN_STOP_HOLD) ||
                   (rev_start_input && rev_fn_q == `SS_FN_STOP_HOLD);

  // Jog takes over, so the stop-hold input is ignored meanwhile.
  // jog ignores hold
  assign hold_active = stop_in && !jog_input;

  start_hold_latch u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .hold_en(hold_active),
    .fwd_in(fwd_in),
    .rev_in(rev_in),
    .held_run(hold_run),
    .held_rev(hold_rev)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************

  start_sel_pkg::stop_mode_t mode;
  logic run_dir_mode;
  logic cmd_run;
  logic cmd_rev;
  logic [6:0] coast_secs;
  logic timer_expired;

  // Decode the stop selection setting.
  // Setting 0 coasts three cycles after removal; a user who wants a
  // soft stop has to pick one of the deceleration settings instead.
  always_comb begin
    mode = start_sel_pkg::MODE_DECEL;
    run_dir_mode = 1'b0;
    coast_secs = 7'h0;
    if (stop_sel_q <= `SS_SEL_COAST_MAX) begin
      mode = start_sel_pkg::MODE_COAST;
      coast_secs = stop_sel_q[6:0];
    end else if (stop_sel_q >= `SS_SEL_RPD_MIN &&
                 stop_sel_q <= `SS_SEL_RPD_MAX) begin
      mode = start_sel_pkg::MODE_COAST;
      run_dir_mode = 1'b1;
      coast_secs = 7'(stop_sel_q - `SS_SEL_RPD_MIN);
    end else if (stop_sel_q == `SS_SEL_RPD_DECEL) begin
      mode = start_sel_pkg::MODE_RPD_DECEL;
      run_dir_mode = 1'b1;
    end
  end

  // Command from level inputs or from the held start.
  // In three-wire mode the latch decides even in run-plus-direction
  // mode, since the start pins then only trigger the latch.
  always_comb begin
    cmd_run = 1'b0;
    cmd_rev = 1'b0;
    if (hold_active) begin
      cmd_run = hold_run;
      cmd_rev = hold_rev;
    end else if (run_dir_mode) begin
      cmd_run = fwd_in;
      cmd_rev = rev_in;
    end else begin
      cmd_run = fwd_in ^ rev_in;
      cmd_rev = rev_in && !fwd_in;
    end
  end

  // ****************************************************************
  // Drive state
  // ****************************************************************

  // Direction of the running command, kept through the stop phase.
  logic dir_q;

  // The timer runs only in the stop phase of a coast setting, so a new
  // start clears the count and a later removal starts it afresh.
  coast_delay_timer #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .arm(state_q == start_sel_pkg::ST_DECEL &&
         mode == start_sel_pkg::MODE_COAST),
    .seconds(coast_secs),
    .expired(timer_expired)
  );

  // Removing the start enters a stop phase, either decelerating with
  // no return to idle or coasting once the timer expires.
  // There is no speed model: deceleration has no end here, so the stop
  // phase lasts until a new start or the coast timer.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      start_sel_pkg::ST_IDLE: begin
        if (cmd_run) begin
          state_d = start_sel_pkg::ST_RUN;
        end
      end
      start_sel_pkg::ST_RUN: begin
        if (!cmd_run) begin
          state_d = start_sel_pkg::ST_DECEL;
        end
      end
      start_sel_pkg::ST_DECEL: begin
        if (cmd_run) begin
          state_d = start_sel_pkg::ST_RUN;
        end else if (timer_expired) begin
          state_d = start_sel_pkg::ST_COAST;
        end
      end
      start_sel_pkg::ST_COAST: begin
        if (cmd_run) begin
          state_d = start_sel_pkg::ST_RUN;
        end
      end
      default: state_d = start_sel_pkg::ST_IDLE;
    endcase
  end

  // State register; the one-hot code is refreshed on every edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= start_sel_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Direction follows the live command while running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 1'b0;
    end else if (cmd_run) begin
      dir_q <= cmd_rev;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Shutoff masks the outputs combinationally, so the motor coasts at
  // once, but leaves the latch and state untouched.
  // immediate shutoff
  assign drive_enable = !output_shutoff_input &&
                        (state_q == start_sel_pkg::ST_RUN ||
                         state_q == start_sel_pkg::ST_DECEL);
  assign run_fwd = drive_enable && state_q == start_sel_pkg::ST_RUN &&
                   !dir_q;
  assign run_rev = drive_enable && state_q == start_sel_pkg::ST_RUN &&
                   dir_q;
  assign decel_stop = drive_enable && state_q == start_sel_pkg::ST_DECEL;
  // Read data leaves straight from its register.
  assign prdata = prdata_q;

endmodule

// ### sim/start_contacts.sv
`timescale 1ns/1ps
// ****************************************************************
// External control contacts wired to the input terminals.
// ****************************************************************
module start_contacts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] want,
  output logic fwd,
  output logic rev,
  output logic stop_hold,
  output logic jog,
  output logic shutoff
);
  // Contacts follow the request one edge late, like a relay would.
  // reversal is a single pulse of the opposite contact.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {shutoff, jog, stop_hold, rev, fwd} <= 5'h00;
    end else begin
      {shutoff, jog, stop_hold, rev, fwd} <= want;
    end
  end
endmodule

// ### sim/start_signal_decoder_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks for the start signal decoder.
// ****************************************************************
module start_signal_decoder_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic fwd_start_input,
  input wire logic rev_start_input,
  input wire logic stop_terminal_input,
  input wire logic jog_input,
  input wire logic output_shutoff_input,
  input wire logic run_fwd,
  input wire logic run_rev,
  input wire logic decel_stop,
  input wire logic drive_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Four cycles leave room for a latch clear and its decel step.
  sequence s_all_low;
    (!fwd_start_input && !rev_start_input && !stop_terminal_input
     && !jog_input)[*4];
  endsequence
  sequence s_fwd_only;
    (fwd_start_input && !rev_start_input && !stop_terminal_input
     && !output_shutoff_input)[*4];
  endsequence
  sequence s_rev_only;
    (rev_start_input && !fwd_start_input && !stop_terminal_input)[*4];
  endsequence
  property p_shutoff;
    output_shutoff_input |-> !drive_enable;
  endproperty
  property p_drive_run;
    (run_fwd || run_rev) && !output_shutoff_input |-> drive_enable;
  endproperty
  property p_decel;
    decel_stop |-> !run_fwd && !run_rev;
  endproperty
  property p_dir;
    !(run_fwd && run_rev);
  endproperty
  property p_all_low;
    s_all_low |-> !run_fwd && !run_rev;
  endproperty
  property p_fwd_only;
    s_fwd_only |-> run_fwd;
  endproperty
  property p_rev_only;
    s_rev_only |-> !run_fwd;
  endproperty
  // Drive may drop, other than by shutoff, only out of the stop phase.
  property p_coast;
    $fell(drive_enable) && !output_shutoff_input |-> $past(decel_stop);
  endproperty
  property p_slverr;
    psel && penable && paddr > 12'h00C |-> pslverr;
  endproperty
  a_shutoff: assert property (p_shutoff)
    else $error("drive on during shutoff");
  a_drive_run: assert property (p_drive_run)
    else $error("running without drive");
  a_decel: assert property (p_decel)
    else $error("decel while running");
  a_dir: assert property (p_dir)
    else $error("both directions at once");
  a_all_low: assert property (p_all_low)
    else $error("running with no start");
  a_fwd_only: assert property (p_fwd_only)
    else $error("forward start not running");
  a_rev_only: assert property (p_rev_only)
    else $error("reverse input gives forward");
  a_coast: assert property (p_coast)
    else $error("drive dropped outside the stop phase");
  a_slverr: assert property (p_slverr)
    else $error("unmapped access without error");
endmodule

bind start_signal_decoder start_signal_decoder_checker chk_u (
  .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .fwd_start_input,
  .rev_start_input, .stop_terminal_input, .jog_input,
  .output_shutoff_input, .run_fwd, .run_rev, .decel_stop, .drive_enable
);

// ### sim/tb_start_signal_decoder.sv
`timescale 1ns/1ps
`include "start_sel_regs.svh"
// ****************************************************************
// Self-checking bench for the start signal decoder.
// ****************************************************************
module tb_start_signal_decoder;
  localparam int SEC = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic fwd, rev, stp, jog, shut, run_fwd, run_rev, decel_stop;
  logic drive_enable, dec;
  logic [4:0] tcmd;
  logic [1:0] c, e, prev;
  int mismatches, checks_done, m, i;
  int sel_tab[2] = '{9999, 8888};
  int coast_tab[2] = '{2, 1003};

  start_signal_decoder #(.SEC_CYCLES(SEC)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fwd_start_input(fwd), .rev_start_input(rev),
    .stop_terminal_input(stp), .jog_input(jog),
    .output_shutoff_input(shut), .run_fwd, .run_rev, .decel_stop,
    .drive_enable
  );
  start_contacts far_u (
    .pclk, .presetn, .want(tcmd), .fwd, .rev, .stop_hold(stp), .jog,
    .shutoff(shut)
  );

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic x, input logic g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %b seen %b", n, x, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] x,
                          input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // One APB transfer; read data and error are taken at the last edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1 rd = prdata;
    if (n >= 20) begin
      mismatches++;
      end_sim();
    end
  endtask

  // Sets the contacts, then lets n edges pass and settles.
  task automatic setin(input logic [4:0] v, input int n);
    @(posedge pclk);
    tcmd <= v;
    repeat (n) @(posedge pclk);
    #1;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected {reverse, forward} from the two start levels.
  function automatic logic [1:0] exp_dir(input int sel, input logic f,
                                         input logic r);
    if (sel == 8888 || (sel >= 1000 && sel <= 1100))
      return f ? (r ? 2'b10 : 2'b01) : 2'b00;
    return (f ^ r) ? {r, f} : 2'b00;
  endfunction

  // Hang guard.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tcmd} = '0;
    seed = 32'hA1D6;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SS_ADDR_STOP_SEL, 32'h0);
    chk_word("stop_sel", 32'h0000270F, rd);
    apb(1'b0, `SS_ADDR_VISIBILITY, 32'h0);
    chk_word("visibility", 32'h00000000, rd);
    apb(1'b0, `SS_ADDR_TERM_FN, 32'h0);
    chk_word("term_fn", 32'h00003D3C, rd);
    // Two-wire levels: every pair, then random pairs, per setting.
    for (m = 0; m < 2; m++) begin
      apb(1'b1, `SS_ADDR_STOP_SEL, 32'(sel_tab[m]));
      apb(1'b0, `SS_ADDR_STOP_SEL, 32'h0);
      chk_word("stop_sel", 32'(sel_tab[m]), rd);
      setin(5'h01, 4);
      prev = 2'b01;
      dec = 1'b0;
      for (i = 0; i < 8; i++) begin
        seed = xs(seed);
        c = (i < 4) ? 2'(i) : seed[1:0];
        setin({3'h0, c}, 4);
        e = exp_dir(sel_tab[m], c[0], c[1]);
        dec = (e == 2'b00) && (dec || prev != 2'b00);
        chk_bit("run_fwd", e[0], run_fwd);
        chk_bit("run_rev", e[1], run_rev);
        chk_bit("decel_stop", dec, decel_stop);
        prev = e;
      end
    end
    // Timed coast after removal, direct and run plus direction.
    for (m = 0; m < 2; m++) begin
      i = (m == 0) ? 2 : 3;
      apb(1'b1, `SS_ADDR_STOP_SEL, 32'(coast_tab[m]));
      setin(5'h01, 4);
      chk_bit("run_fwd", 1'b1, run_fwd);
      setin(5'h00, i * SEC - 5);
      chk_bit("drive_enable", 1'b1, drive_enable);
      setin(5'h00, 13);
      chk_bit("drive_enable", 1'b0, drive_enable);
    end
    // Refused writes and an unmapped place.
    apb(1'b1, `SS_ADDR_VISIBILITY, 32'h1);
    apb(1'b1, `SS_ADDR_STOP_SEL, 32'h000022B8);
    apb(1'b0, `SS_ADDR_STOP_SEL, 32'h0);
    chk_word("stop_sel", 32'h000003EB, rd);
    apb(1'b1, `SS_ADDR_VISIBILITY, 32'h0);
    apb(1'b1, `SS_ADDR_STOP_SEL, 32'h00001388);
    apb(1'b0, `SS_ADDR_STOP_SEL, 32'h0);
    chk_word("stop_sel", 32'h000003EB, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk_bit("pslverr", 1'b1, err);
    chk_word("unmapped", 32'h00000000, rd);
    // Unrouted stop-hold terminal must not latch.
    apb(1'b1, `SS_ADDR_STOP_SEL, 32'h0000270F);
    setin(5'h05, 3);
    setin(5'h04, 5);
    chk_bit("run_fwd", 1'b0, run_fwd);
    apb(1'b1, `SS_ADDR_TERM_FN, 32'h00193C3D);
    apb(1'b0, `SS_ADDR_TERM_FN, 32'h0);
    chk_word("term_fn", 32'h00193D3C, rd);
    // Three-wire: latch, shutoff, reverse pulse, release.
    setin(5'h05, 3);
    setin(5'h04, 5);
    chk_bit("run_fwd", 1'b1, run_fwd);
    setin(5'h14, 3);
    chk_bit("drive_enable", 1'b0, drive_enable);
    setin(5'h04, 3);
    chk_bit("run_fwd", 1'b1, run_fwd);
    setin(5'h06, 3);
    setin(5'h04, 5);
    chk_bit("run_rev", 1'b1, run_rev);
    setin(5'h00, 5);
    chk_bit("run_rev", 1'b0, run_rev);
    chk_bit("decel_stop", 1'b1, decel_stop);
    // Relatch forward; jog with stop-hold still on must drop the hold.
    setin(5'h05, 3);
    setin(5'h04, 5);
    chk_bit("run_fwd", 1'b1, run_fwd);
    setin(5'h0C, 5);
    chk_bit("run_fwd", 1'b0, run_fwd);
    end_sim();
  end
endmodule
